// ### quad_corr_sync_params.svh
// Offsets, field positions, reset values and widths of the sync-select bank.
// Included by the sync-select bank module; holds definitions only.
`ifndef QUAD_CORR_SYNC_PARAMS_SVH
`define QUAD_CORR_SYNC_PARAMS_SVH

// Register indices; the Wishbone byte address is four times the index.
`define QCS_IDX_RSVD_A 6'h1C
`define QCS_IDX_RSVD_B 6'h1D
`define QCS_IDX_SYNC_SEL 6'h1E
`define QCS_IDX_CONTROL 6'h3F

`define QCS_SYNC_SEL_RESET 16'h1111
`define QCS_RSVD_RESET 16'h0000
`define QCS_RSVD_NIBBLE 4'h1

// Field positions inside the sync-select register.
`define QCS_OFFSET_MSB 15
`define QCS_OFFSET_LSB 12
`define QCS_RSVD_HI_MSB 11
`define QCS_RSVD_HI_LSB 8
`define QCS_CORR_MSB 7
`define QCS_CORR_LSB 4
`define QCS_RSVD_LO_MSB 3
`define QCS_RSVD_LO_LSB 0

// Field positions inside the control and status register.
`define QCS_CTL_SW_SYNC 0
`define QCS_STS_OFFSET_PEND 8
`define QCS_STS_CORR_PEND 9

`endif

// ### quad_corr_sync_pkg.sv
// Types shared by the sync-select bank and its trigger stages.
// Assumes nothing of its surroundings.
package quad_corr_sync_pkg;

  // One bit per sync source, in the order of the mask bits (msb first).
  typedef struct packed {
    logic sw_sync;
    logic ext_sync;
    logic output_strobe;
    logic auto_write;
  } sync_events_t;

  typedef logic [3:0] sync_mask_t;

endpackage

// ### sync_trigger.sv
// One shadow-to-active transfer stage: mask gating and pending tracking.
// Assumes single-cycle event pulses synchronous to clk_i.
`timescale 1ns/1ps
module sync_trigger (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire quad_corr_sync_pkg::sync_mask_t mask_i,
  input wire quad_corr_sync_pkg::sync_events_t events_i,
  input wire logic shadow_wr_i,
  output logic load_o,
  output logic pending_o
);

  logic fire;

  // Any enabled source fires; several may be enabled together.
  assign fire = |(mask_i & events_i); // R3

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_o <= 1'b0;
    end else begin
      load_o <= fire; // R10
    end
  end

  // A shadow write in the same cycle as a transfer stays pending, since
  // the transfer copies the value that stood before the write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_o <= 1'b0;
    end else if (shadow_wr_i) begin
      pending_o <= 1'b1;
    end else if (fire) begin
      pending_o <= 1'b0; // R10
    end
  end

  property p_load_follows_fire;
    @(posedge clk_i) disable iff (rst_i)
      fire |=> load_o;
  endproperty
  a_load_follows_fire: assert property (p_load_follows_fire) // R3
    else $error("Enabled sync event did not produce a load.");

  property p_zero_mask_holds;
    @(posedge clk_i) disable iff (rst_i)
      (mask_i == 4'h0) |=> !load_o;
  endproperty
  a_zero_mask_holds: assert property (p_zero_mask_holds) // R10
    else $error("Load occurred with an all-zero mask.");

  property p_pending_kept;
    @(posedge clk_i) disable iff (rst_i)
      (pending_o && !fire) |=> pending_o;
  endproperty
  a_pending_kept: assert property (p_pending_kept) // R10
    else $error("Pending flag dropped without a transfer.");

endmodule // sync_trigger

// ### quad_corr_sync_select.sv
// Sync-select register bank for the quadrature correction shadow registers.
// Assumes a classic Wishbone master on clk_i and synchronous sync inputs.
// What this block does
// R1: Bits 15:12 mask which events copy shadow offsets into active offsets.
// R2: Offset mask: 15 software sync, 14 sync pin, 13 strobe, 12 write.
// R3: Any combination of enabled sources is allowed; any one triggers transfer.
// R4: Bits 7:4 mask which events copy shadow gain and phase corrections.
// R5: Correction mask: 7 software sync, 6 sync pin, 5 strobe, 4 write.
// R6: Sync-select resets to 0x1111, so only write auto-sync is enabled.
// R7: Bits 11:8 and 3:0 are reserved, read 0001 and do nothing.
// R8: Registers at 0x1C and 0x1D are reserved, read zero, no function.
// R9: Software raises the software sync bit, then must clear it again.
// R10: An all-zero mask never transfers; shadow values stay pending.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "quad_corr_sync_params.svh"
module quad_corr_sync_select (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_sync_i,
  input wire logic output_strobe_input_i,
  input wire logic reg_write_i,
  input wire logic offset_shadow_wr_i,
  input wire logic correction_shadow_wr_i,
  output logic offset_load_o,
  output logic correction_load_o,
  output logic offset_pending_o,
  output logic correction_pending_o
);

  logic [15:0] sync_sel_q;
  logic sw_sync_q;
  logic sw_prev_q;
  logic ext_prev_q;
  logic strobe_prev_q;
  logic wr_event_q;
  logic [31:0] dat_d;
  logic bus_req;
  logic bus_wr;
  logic [5:0] idx;
  quad_corr_sync_pkg::sync_events_t events;
  quad_corr_sync_pkg::sync_mask_t offset_mask;
  quad_corr_sync_pkg::sync_mask_t corr_mask;

  // Merges byte lanes of a write into a 16-bit register value.
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  // Reserved nibbles are forced, so software writes cannot change them.
  function automatic logic [15:0] fix_reserved(input logic [15:0] v);
    logic [15:0] res;
    res = v;
    res[`QCS_RSVD_HI_MSB:`QCS_RSVD_HI_LSB] = `QCS_RSVD_NIBBLE;
    res[`QCS_RSVD_LO_MSB:`QCS_RSVD_LO_LSB] = `QCS_RSVD_NIBBLE;
    return res;
  endfunction

  assign idx = adr_i[7:2];
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = bus_req && we_i;

  // Wishbone ack: one cycle after the request, dropped the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_sel_q <= `QCS_SYNC_SEL_RESET; // R6
    end else if (bus_wr && idx == `QCS_IDX_SYNC_SEL) begin
      sync_sel_q <= fix_reserved(lane_merge(sync_sel_q, dat_i, sel_i)); // R7
    end
  end

  // The software sync bit is a plain level; only its rising edge counts,
  // so software must clear it before another sync can be raised.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_sync_q <= 1'b0;
    end else if (bus_wr && idx == `QCS_IDX_CONTROL && sel_i[0]) begin
      sw_sync_q <= dat_i[`QCS_CTL_SW_SYNC]; // R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      sw_prev_q <= sw_sync_q;
      ext_prev_q <= ext_sync_i;
      strobe_prev_q <= output_strobe_input_i;
    end
  end

  // Any register write, on this bus or elsewhere in the device, auto-syncs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_event_q <= 1'b0;
    end else begin
      wr_event_q <= bus_wr || reg_write_i;
    end
  end

  always_comb begin
    events.sw_sync = sw_sync_q && !sw_prev_q;
    events.ext_sync = ext_sync_i && !ext_prev_q;
    events.output_strobe = output_strobe_input_i && !strobe_prev_q;
    events.auto_write = wr_event_q;
  end

  assign offset_mask = sync_sel_q[`QCS_OFFSET_MSB:`QCS_OFFSET_LSB]; // R1
  assign corr_mask = sync_sel_q[`QCS_CORR_MSB:`QCS_CORR_LSB]; // R4

  // Mask bit order matches the event struct: sw, pin, strobe, write.
  sync_trigger u_offset_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mask_i(offset_mask), // R2
    .events_i(events),
    .shadow_wr_i(offset_shadow_wr_i),
    .load_o(offset_load_o),
    .pending_o(offset_pending_o)
  );

  sync_trigger u_corr_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mask_i(corr_mask), // R5
    .events_i(events),
    .shadow_wr_i(correction_shadow_wr_i),
    .load_o(correction_load_o),
    .pending_o(correction_pending_o)
  );

  always_comb begin
    dat_d = 32'h0000_0000;
    unique case (idx)
      `QCS_IDX_RSVD_A: dat_d[15:0] = `QCS_RSVD_RESET; // R8
      `QCS_IDX_RSVD_B: dat_d[15:0] = `QCS_RSVD_RESET; // R8
      `QCS_IDX_SYNC_SEL: dat_d[15:0] = sync_sel_q;
      `QCS_IDX_CONTROL: begin
        dat_d[`QCS_CTL_SW_SYNC] = sw_sync_q;
        dat_d[`QCS_STS_OFFSET_PEND] = offset_pending_o;
        dat_d[`QCS_STS_CORR_PEND] = correction_pending_o;
      end
      default: dat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_o <= dat_d;
    end
  end

  property p_reserved_nibbles;
    @(posedge clk_i) disable iff (rst_i)
      sync_sel_q[11:8] == 4'h1 && sync_sel_q[3:0] == 4'h1;
  endproperty
  a_reserved_nibbles: assert property (p_reserved_nibbles) // R7
    else $error("Reserved sync-select nibble is not 0001.");

  property p_reset_value;
    @(posedge clk_i) rst_i |=> sync_sel_q == 16'h1111;
  endproperty
  a_reset_value: assert property (p_reset_value) // R6
    else $error("Sync-select did not reset to 0x1111.");

  property p_rsvd_read_zero;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !we_i && (idx == 6'h1C || idx == 6'h1D))
        |=> ack_o && dat_o == 32'h0000_0000;
  endproperty
  a_rsvd_read_zero: assert property (p_rsvd_read_zero) // R8
    else $error("Reserved register did not read zero.");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Ack held longer than one cycle.");

  property p_offset_strobe;
    @(posedge clk_i) disable iff (rst_i)
      (sync_sel_q[13] && output_strobe_input_i && !strobe_prev_q)
        |=> offset_load_o;
  endproperty
  a_offset_strobe: assert property (p_offset_strobe) // R2
    else $error("Strobe did not load offsets while enabled.");

  property p_corr_pin;
    @(posedge clk_i) disable iff (rst_i)
      (sync_sel_q[6] && ext_sync_i && !ext_prev_q) |=> correction_load_o;
  endproperty
  a_corr_pin: assert property (p_corr_pin) // R5
    else $error("Sync pin did not load corrections while enabled.");

  property p_auto_write;
    @(posedge clk_i) disable iff (rst_i)
      (reg_write_i && sync_sel_q[12] && sync_sel_q[4] && !bus_wr)
        |=> ##1 offset_load_o && correction_load_o;
  endproperty
  a_auto_write: assert property (p_auto_write) // R3
    else $error("Register write did not auto-sync both groups.");

  property p_sw_sync_once;
    @(posedge clk_i) disable iff (rst_i)
      (sw_sync_q && sw_prev_q && !ext_sync_i && !output_strobe_input_i
        && !wr_event_q) |=> !offset_load_o;
  endproperty
  a_sw_sync_once: assert property (p_sw_sync_once) // R9
    else $error("Held software sync bit caused a repeated load.");

  property p_offset_mask_off;
    @(posedge clk_i) disable iff (rst_i)
      (sync_sel_q[15:12] == 4'h0) |=> !offset_load_o;
  endproperty
  a_offset_mask_off: assert property (p_offset_mask_off) // R1
    else $error("Offsets loaded with an empty offset mask.");

  property p_corr_mask_sw;
    @(posedge clk_i) disable iff (rst_i)
      (sync_sel_q[7:4] == 4'h8 && !(sw_sync_q && !sw_prev_q))
        |=> !correction_load_o;
  endproperty
  a_corr_mask_sw: assert property (p_corr_mask_sw) // R4
    else $error("Corrections loaded by a source not in the mask.");

endmodule // quad_corr_sync_select

// ### quad_corr_sync_select_bench.sv
// Self-checking bench for the quad_corr_sync_select register bank.
// Assumes the design's classic Wishbone timing and edge-detected sync inputs.
`timescale 1ns/1ps
module quad_corr_sync_select_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, dat_o, rd, m, no, nc;
  logic ack_o, ext = 1'b0, strb = 1'b0, regw = 1'b0;
  logic off_wr = 1'b0, cor_wr = 1'b0;
  logic off_ld, cor_ld, off_pd, cor_pd;
  int mismatches = 0, checked = 0;

  quad_corr_sync_select i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .ext_sync_i(ext),
    .output_strobe_input_i(strb), .reg_write_i(regw),
    .offset_shadow_wr_i(off_wr), .correction_shadow_wr_i(cor_wr),
    .offset_load_o(off_ld), .correction_load_o(cor_ld),
    .offset_pending_o(off_pd), .correction_pending_o(cor_pd));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      mismatches++;
    end
  endtask

  // Waits on ack with a bound, so a silent slave ends the run cleanly.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      $display("CHECK FAILED at %0t: no ack from the register bus", $time);
      mismatches++;
      test_done();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string msg);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e, msg);
  endtask

  // Counts load pulses over a fixed window; a held level must not refire.
  task automatic watch();
    no = 32'h0;
    nc = 32'h0;
    repeat (8) begin
      @(posedge clk_i);
      no += {31'h0, off_ld === 1'b1};
      nc += {31'h0, cor_ld === 1'b1};
    end
  endtask

  task automatic arm();
    repeat (4) @(posedge clk_i);
    off_wr <= 1'b1;
    cor_wr <= 1'b1;
    @(posedge clk_i);
    off_wr <= 1'b0;
    cor_wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic fire(input int i);
    case (i)
      3: wb(1'b1, 8'hFC, 32'h1, rd);
      2: ext <= 1'b1;
      1: strb <= 1'b1;
      default: begin
        regw <= 1'b1;
        @(posedge clk_i);
        regw <= 1'b0;
      end
    endcase
  endtask

  task automatic quiet();
    ext <= 1'b0;
    strb <= 1'b0;
    wb(1'b1, 8'hFC, 32'h0, rd);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    $display("CHECK FAILED at %0t: run did not finish in time", $time);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h78, 32'h1111, "sync select reset");
    rchk(8'h70, 32'h0, "reserved a reset");
    rchk(8'h74, 32'h0, "reserved b reset");
    rchk(8'hFC, 32'h0, "status reset");
    // Out of reset only a register write may move shadow values across.
    arm();
    fire(0);
    watch();
    chk(no, 32'h1, "default offset auto-sync");
    chk(nc, 32'h1, "default correction auto-sync");
    ext <= 1'b1;
    strb <= 1'b1;
    watch();
    chk(no, 32'h0, "default offset pin and strobe");
    chk(nc, 32'h0, "default correction pin and strobe");
    quiet();
    $display("Test reset values done");
    wb(1'b1, 8'h70, 32'hFFFF, rd);
    wb(1'b1, 8'h74, 32'hFFFF, rd);
    wb(1'b1, 8'h40, 32'hFFFF, rd);
    rchk(8'h70, 32'h0, "reserved a write");
    rchk(8'h74, 32'h0, "reserved b write");
    rchk(8'h40, 32'h0, "unmapped read");
    wb(1'b1, 8'h78, 32'h0, rd);
    rchk(8'h78, 32'h0101, "reserved nibbles");
    wb(1'b1, 8'h78, 32'hFFFF, rd);
    rchk(8'h78, 32'hF1F1, "reserved nibbles");
    $display("Test reserved fields done");
    // Group 0 is the offset mask, group 1 the correction mask.
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 4; i++) begin
        m = 32'h0101 | (32'h10 << (i + 8 * (1 - g)));
        wb(1'b1, 8'h78, m, rd);
        rchk(8'h78, m, "mask readback");
        arm();
        fire(i);
        watch();
        chk(no, {31'h0, g == 0}, "offset loads");
        chk(nc, {31'h0, g == 1}, "correction loads");
        chk({31'h0, off_pd}, {31'h0, g == 1}, "offset pending");
        chk({31'h0, cor_pd}, {31'h0, g == 0}, "corr pending");
        rchk(8'hFC, (32'h200 >> g) | {31'h0, i == 3}, "status");
        quiet();
      end
    end
    $display("Test single sources done");
    wb(1'b1, 8'h78, 32'hF1F1, rd);
    arm();
    ext <= 1'b1;
    strb <= 1'b1;
    watch();
    chk(no, 32'h1, "offset joint loads");
    chk(nc, 32'h1, "correction joint loads");
    quiet();
    $display("Test combined sources done");
    // Both masks empty: pin, strobe and register write fire at once and nothing may load.
    wb(1'b1, 8'h78, 32'h0101, rd);
    arm();
    ext <= 1'b1;
    strb <= 1'b1;
    fire(0);
    watch();
    chk(no, 32'h0, "offset loads with empty mask");
    chk(nc, 32'h0, "correction loads with empty mask");
    chk({31'h0, off_pd & cor_pd}, 32'h1, "both still pending");
    quiet();
    $display("Test empty masks done");
    test_done();
  end
endmodule // quad_corr_sync_select_bench
